// file: aic_pkg.sv
// aic_pkg: register map, field layout, codes and lookup tables of the converter control block.
// assumes a 16-bit register port with byte offsets as printed; shared by all aic modules.
package aic_pkg;

  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 16;
  localparam int RES_W      = 10;
  localparam int NUM_FLAGS  = 6;
  localparam int SAMP_CNT_W = 11;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTL0   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTL1   = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_CTL2   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WLO    = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_WHI    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MCTL   = 8'h0a;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_IE     = 8'h1a;
  localparam logic [ADDR_W-1:0] OFS_IFG    = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IV     = 8'h1e;

  // reset values
  localparam logic [DATA_W-1:0] RST_CTL1 = 16'h0000;
  localparam logic [DATA_W-1:0] RST_CTL2 = 16'h1000;
  localparam logic [DATA_W-1:0] RST_WLO  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_WHI  = 16'hff03;
  localparam logic [DATA_W-1:0] RST_MCTL = 16'h0000;
  localparam logic [DATA_W-1:0] RST_IE   = 16'h0000;

  // control register 0 fields
  localparam int CTL0_SHT_LSB = 8;
  localparam int CTL0_MSC_BIT = 7;
  localparam int CTL0_ON_BIT  = 4;
  localparam int CTL0_ENC_BIT = 1;
  localparam int CTL0_SC_BIT  = 0;

  // other writable masks and fields
  localparam logic [DATA_W-1:0] CTL1_WMASK   = 16'h0ffe;
  localparam logic [DATA_W-1:0] CTL2_WMASK   = 16'h031c;
  localparam logic [DATA_W-1:0] MCTL_WMASK   = 16'h00ff;
  localparam logic [DATA_W-1:0] FLAG_MASK    = 16'h003f;
  localparam int                CTL1_SEQ_LSB = 1;
  localparam int                CTL1_BSY_BIT = 0;

  // flag and enable bit positions
  localparam int FLG_READY = 0;
  localparam int FLG_OVF   = 1;
  localparam int FLG_TOV   = 2;
  localparam int FLG_HIGH  = 3;
  localparam int FLG_LOW   = 4;
  localparam int FLG_IN    = 5;

  // vector codes
  localparam logic [DATA_W-1:0] VEC_NONE  = 16'h0000;
  localparam logic [DATA_W-1:0] VEC_OVF   = 16'h0002;
  localparam logic [DATA_W-1:0] VEC_TOV   = 16'h0004;
  localparam logic [DATA_W-1:0] VEC_HIGH  = 16'h0006;
  localparam logic [DATA_W-1:0] VEC_LOW   = 16'h0008;
  localparam logic [DATA_W-1:0] VEC_IN    = 16'h000a;
  localparam logic [DATA_W-1:0] VEC_READY = 16'h000c;

  // sampling length per sample_time_sel code, in converter clock cycles
  localparam logic [SAMP_CNT_W-1:0] SAMPLE_LEN [16] = '{
    11'h004, 11'h008, 11'h010, 11'h020, 11'h040, 11'h060, 11'h080, 11'h0c0,
    11'h100, 11'h180, 11'h200, 11'h300, 11'h400, 11'h400, 11'h400, 11'h400};

  typedef enum logic [1:0] {
    SEQ_SINGLE     = 2'b00,
    SEQ_CHANNELS   = 2'b01,
    SEQ_REP_SINGLE = 2'b10,
    SEQ_REP_CHAN   = 2'b11
  } aic_conseq_e;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10
  } aic_state_e;

  typedef struct packed {
    logic [3:0] sample_time_sel;
    logic       multi_sample_mode;
    logic       converter_power_on;
    logic       conversion_enable;
  } aic_ctl0_s;

  function automatic logic [SAMP_CNT_W-1:0] aic_sample_len(input logic [3:0] sel);
    aic_sample_len = SAMPLE_LEN[sel];
  endfunction : aic_sample_len

  // one-hot of the highest-priority pending source
  function automatic logic [NUM_FLAGS-1:0] aic_top_src(input logic [NUM_FLAGS-1:0] pend);
    aic_top_src = '0;
    if (pend[FLG_OVF])        aic_top_src[FLG_OVF]   = 1'b1;
    else if (pend[FLG_TOV])   aic_top_src[FLG_TOV]   = 1'b1;
    else if (pend[FLG_HIGH])  aic_top_src[FLG_HIGH]  = 1'b1;
    else if (pend[FLG_LOW])   aic_top_src[FLG_LOW]   = 1'b1;
    else if (pend[FLG_IN])    aic_top_src[FLG_IN]    = 1'b1;
    else if (pend[FLG_READY]) aic_top_src[FLG_READY] = 1'b1;
  endfunction : aic_top_src

  function automatic logic [DATA_W-1:0] aic_vec_code(input logic [NUM_FLAGS-1:0] top);
    aic_vec_code = VEC_NONE;
    if (top[FLG_OVF])        aic_vec_code = VEC_OVF;
    else if (top[FLG_TOV])   aic_vec_code = VEC_TOV;
    else if (top[FLG_HIGH])  aic_vec_code = VEC_HIGH;
    else if (top[FLG_LOW])   aic_vec_code = VEC_LOW;
    else if (top[FLG_IN])    aic_vec_code = VEC_IN;
    else if (top[FLG_READY]) aic_vec_code = VEC_READY;
  endfunction : aic_vec_code

endpackage : aic_pkg

// file: aic_sample_timer.sv
// aic_sample_timer: counts converter clock ticks for the sampling period.
// assumes tick_in is a one-cycle enable in the core clock domain.
module aic_sample_timer
  import aic_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic       start_in,
  input  wire logic       abort_in,
  input  wire logic       tick_in,
  input  wire logic [3:0] sht_in,
  output logic            done_out
);

  logic [SAMP_CNT_W-1:0] cnt_q;
  logic                  run_q;

  // length is read live so a field change while running takes effect at once
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cnt_q    <= '0;
      run_q    <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (abort_in)
        run_q <= 1'b0;
      else if (start_in)
      begin
        run_q <= 1'b1;
        cnt_q <= '0;
      end
      else if (run_q && tick_in)
      begin
        if (cnt_q + 11'h001 >= aic_sample_len(sht_in)) // [R14]
        begin
          run_q    <= 1'b0;
          done_out <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  timer_done_src_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R14]
    done_out |-> $past(run_q) && $past(tick_in))
    else $error("sample timer finished without a running tick");

endmodule : aic_sample_timer

// file: aic_converter_ctl.sv
// aic_converter_ctl: control, sequencing, window comparator and interrupt vector of a 10-bit converter.
// assumes a synchronous register port, an analog core answering conv_start_out with conv_done_in,
// and a one-cycle converter clock tick in the core clock domain.
// How it works
// [R1] loading a new result sets the conversion-ready flag
// [R2] interrupt request for ready needs its enable and the global enable
// [R3] new result over an unread one flags result overflow
// [R4] a trigger arriving during a conversion flags conversion-time overflow
// [R5] each completed conversion pulses the dma trigger when ready enable is clear
// [R6] all sources are prioritised into one vector register
// [R7] the vector shows only pending and enabled sources
// [R8] reading the vector clears the top source, never the ready flag
// [R9] reading the result or writing flags clears conversion-ready
// [R10] any vector write clears every flag
// [R11] interrupt stays raised while another enabled source remains pending
// [R12] codes: 0 none, 2 overflow, 4 time overflow, 6 high, 8 low, 10 in
// [R13] conversion-ready is lowest priority with code 12
// [R14] sample-time codes select 4 to 768 cycles, codes 12 to 15 give 1024
// [R15] with multi-sample mode in a sequence or repeat mode only the first edge starts, later conversions follow
// [R16] software start triggers once, self-clears, may come with enable
// [R17] control fields change only while enable is low, taking effect at once
// [R18] reserved control bits read zero and ignore writes; control register 2 bit 12 resets to one, a write with enable low clears it
// [R19] window flags: low below low, high above high, in strictly between
// [R20] window flags are set only with each new result, cleared by software
module aic_converter_ctl
  import aic_pkg::*;
#(
  parameter int CH_W = 4
)
(
  input  wire logic              core_clk_in,
  input  wire logic              reset_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  input  wire logic              global_irq_enable_in,
  input  wire logic              converter_clock_in,
  input  wire logic              sample_input_signal_in,
  input  wire logic              conv_done_in,
  input  wire logic [RES_W-1:0]  conv_data_in,
  output logic                   irq_out,
  output logic                   dma_trig_out,
  output logic                   conv_start_out,
  output logic                   sampling_out,
  output logic      [CH_W-1:0]   channel_out,
  output logic                   converter_power_on_out
);

  aic_ctl0_s             ctl0_q;
  logic                  sc_q;
  logic [DATA_W-1:0]     ctl1_q;
  logic [DATA_W-1:0]     ctl2_q;
  logic [DATA_W-1:0]     wlo_q;
  logic [DATA_W-1:0]     whi_q;
  logic [DATA_W-1:0]     mctl_q;
  logic [DATA_W-1:0]     ie_q;
  logic [RES_W-1:0]      result_q;
  logic [NUM_FLAGS-1:0]  flags_q;
  logic [NUM_FLAGS-1:0]  flags_d;
  aic_state_e            state_q;
  logic                  unread_q;
  logic                  shi_q;
  logic                  auto_q;
  logic                  seq_pend_q;

  logic                  wr_ctl0;
  logic                  rd_iv;
  logic                  rd_res;
  logic                  shi_rise;
  logic                  trig_req;
  logic                  busy;
  logic                  accept;
  logic                  tov_evt;
  logic                  load;
  logic                  more_seq;
  logic                  go_on;
  logic                  abort;
  logic                  timer_start;
  logic                  timer_done;
  logic                  locked;
  aic_conseq_e           conseq;
  logic [NUM_FLAGS-1:0]  pend;
  logic [NUM_FLAGS-1:0]  top;
  logic [DATA_W-1:0]     res_word;
  logic [DATA_W-1:0]     ctl0_word;

  assign wr_ctl0   = reg_wr_in && reg_addr_in == OFS_CTL0;
  assign rd_iv     = reg_rd_in && reg_addr_in == OFS_IV;
  assign rd_res    = reg_rd_in && reg_addr_in == OFS_RESULT;
  assign locked    = ctl0_q.conversion_enable;
  assign conseq    = aic_conseq_e'(ctl1_q[CTL1_SEQ_LSB +: 2]);
  assign shi_rise  = sample_input_signal_in && !shi_q;
  assign trig_req  = (sc_q || shi_rise) && ctl0_q.conversion_enable && ctl0_q.converter_power_on;
  assign busy      = state_q != ST_IDLE;
  assign accept    = trig_req && !busy;
  assign tov_evt   = trig_req && busy && !auto_q; // [R4]
  assign load      = state_q == ST_CONVERT && conv_done_in;
  assign more_seq  = conseq[0] && chan_nonzero(channel_out);
  assign abort     = busy && (!ctl0_q.converter_power_on
                     || (!ctl0_q.conversion_enable && conseq == SEQ_SINGLE));
  // automatic follow-on only with multi-sample mode in a sequence or repeat mode
  assign go_on     = load && ctl0_q.multi_sample_mode && conseq != SEQ_SINGLE
                     && (more_seq || (conseq[1] && ctl0_q.conversion_enable)); // [R15]
  assign timer_start = !abort && ((state_q == ST_IDLE && accept) || go_on);
  assign pend      = flags_q & ie_q[NUM_FLAGS-1:0]; // [R7]
  assign top       = aic_top_src(pend); // [R6]
  assign res_word  = DATA_W'(result_q);
  assign ctl0_word = (DATA_W'(ctl0_q.sample_time_sel) << CTL0_SHT_LSB)
                   | (DATA_W'(ctl0_q.multi_sample_mode) << CTL0_MSC_BIT)
                   | (DATA_W'(ctl0_q.converter_power_on) << CTL0_ON_BIT)
                   | (DATA_W'(ctl0_q.conversion_enable) << CTL0_ENC_BIT); // [R18]

  function automatic logic chan_nonzero(input logic [CH_W-1:0] ch);
    chan_nonzero = ch != '0;
  endfunction : chan_nonzero

  aic_sample_timer u_timer (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .start_in    (timer_start),
    .abort_in    (abort),
    .tick_in     (converter_clock_in),
    .sht_in      (ctl0_q.sample_time_sel),
    .done_out    (timer_done)
  );

  // control register 0; the start bit is a one-cycle pulse and reads back zero
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctl0_q <= '0;
      sc_q   <= 1'b0;
    end
    else
    begin
      sc_q <= wr_ctl0 && reg_wdata_in[CTL0_SC_BIT]; // [R16]
      if (wr_ctl0)
      begin
        ctl0_q.conversion_enable <= reg_wdata_in[CTL0_ENC_BIT];
        if (!locked) // [R17]
        begin
          ctl0_q.sample_time_sel    <= reg_wdata_in[CTL0_SHT_LSB +: 4];
          ctl0_q.multi_sample_mode  <= reg_wdata_in[CTL0_MSC_BIT];
          ctl0_q.converter_power_on <= reg_wdata_in[CTL0_ON_BIT];
        end
      end
    end
  end

  // remaining configuration registers
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctl1_q <= RST_CTL1;
      ctl2_q <= RST_CTL2;
      wlo_q  <= RST_WLO;
      whi_q  <= RST_WHI;
      mctl_q <= RST_MCTL;
      ie_q   <= RST_IE;
    end
    else if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        OFS_CTL1: if (!locked) ctl1_q <= reg_wdata_in & CTL1_WMASK; // [R17]
        OFS_CTL2: if (!locked) ctl2_q <= reg_wdata_in & CTL2_WMASK; // [R17]
        OFS_MCTL: if (!locked) mctl_q <= reg_wdata_in & MCTL_WMASK; // [R17]
        OFS_WLO:  wlo_q <= reg_wdata_in;
        OFS_WHI:  whi_q <= reg_wdata_in;
        OFS_IE:   ie_q  <= reg_wdata_in & FLAG_MASK;
        default:  ;
      endcase
    end
  end

  // sequencer
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q        <= ST_IDLE;
      sampling_out   <= 1'b0;
      conv_start_out <= 1'b0;
      auto_q         <= 1'b0;
    end
    else
    begin
      conv_start_out <= 1'b0;
      if (abort)
      begin
        state_q      <= ST_IDLE;
        sampling_out <= 1'b0;
        auto_q       <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          ST_IDLE:
          begin
            if (accept)
            begin
              state_q      <= ST_SAMPLE;
              sampling_out <= 1'b1;
              // later edges are ignored while the automatic run lasts
              auto_q       <= ctl0_q.multi_sample_mode && conseq != SEQ_SINGLE; // [R15]
            end
          end
          ST_SAMPLE:
          begin
            if (timer_done)
            begin
              state_q        <= ST_CONVERT;
              sampling_out   <= 1'b0;
              conv_start_out <= 1'b1;
            end
          end
          ST_CONVERT:
          begin
            if (conv_done_in)
            begin
              state_q      <= go_on ? ST_SAMPLE : ST_IDLE; // [R15]
              sampling_out <= go_on;
              auto_q       <= go_on;
            end
          end
          default:
          begin
            state_q      <= ST_IDLE;
            sampling_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // channel pointer walks down to zero in sequence modes
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      channel_out <= '0;
      seq_pend_q  <= 1'b0;
    end
    else if (abort || !ctl0_q.conversion_enable && !busy)
      seq_pend_q <= 1'b0;
    else if (accept)
      channel_out <= seq_pend_q ? channel_out : mctl_q[CH_W-1:0];
    else if (load)
    begin
      channel_out <= more_seq ? channel_out - 1'b1 : mctl_q[CH_W-1:0];
      seq_pend_q  <= more_seq;
    end
  end

  // result register and its unread marker
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      result_q <= '0;
      unread_q <= 1'b0;
      shi_q    <= 1'b0;
    end
    else
    begin
      shi_q <= sample_input_signal_in;
      if (load)
        result_q <= conv_data_in;
      else if (reg_wr_in && reg_addr_in == OFS_RESULT)
        result_q <= reg_wdata_in[RES_W-1:0];
      unread_q <= load || (unread_q && !rd_res);
    end
  end

  // flags: clears first, hardware sets last so a same-cycle event is kept
  always_comb
  begin
    logic [NUM_FLAGS-1:0] base;
    logic [NUM_FLAGS-1:0] clr;
    logic [NUM_FLAGS-1:0] set;
    base = flags_q;
    clr  = '0;
    set  = '0;
    if (reg_wr_in && reg_addr_in == OFS_IFG)
      base = reg_wdata_in[NUM_FLAGS-1:0]; // [R9]
    if (reg_wr_in && reg_addr_in == OFS_IV)
      base = '0; // [R10]
    if (rd_iv)
      clr = top & ~(NUM_FLAGS'(1) << FLG_READY); // [R8]
    if (rd_res)
      clr[FLG_READY] = 1'b1; // [R9]
    if (load)
    begin
      set[FLG_READY] = 1'b1; // [R1]
      set[FLG_OVF]   = unread_q && !rd_res; // [R3]
      set[FLG_LOW]   = res_in_word(conv_data_in) < wlo_q; // [R19] [R20]
      set[FLG_HIGH]  = res_in_word(conv_data_in) > whi_q; // [R19] [R20]
      set[FLG_IN]    = res_in_word(conv_data_in) > wlo_q && res_in_word(conv_data_in) < whi_q; // [R19]
    end
    set[FLG_TOV] = tov_evt; // [R4]
    flags_d = (base & ~clr) | set;
  end

  function automatic logic [DATA_W-1:0] res_in_word(input logic [RES_W-1:0] r);
    res_in_word = DATA_W'(r);
  endfunction : res_in_word

  // flags, interrupt and dma outputs
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      flags_q      <= '0;
      irq_out      <= 1'b0;
      dma_trig_out <= 1'b0;
    end
    else
    begin
      flags_q      <= flags_d;
      // level request re-raises while any enabled source stays pending
      irq_out      <= global_irq_enable_in && (pend != '0); // [R2] [R11]
      dma_trig_out <= load && !ie_q[FLG_READY]; // [R5]
    end
  end

  // read port: data stands for exactly one cycle after the strobe
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      reg_rdata_out <= '0;
    else if (!reg_rd_in)
      reg_rdata_out <= '0;
    else
    begin
      unique case (reg_addr_in)
        OFS_CTL0:   reg_rdata_out <= ctl0_word; // [R18]
        OFS_CTL1:   reg_rdata_out <= ctl1_q | (DATA_W'(busy) << CTL1_BSY_BIT);
        OFS_CTL2:   reg_rdata_out <= ctl2_q;
        OFS_WLO:    reg_rdata_out <= wlo_q;
        OFS_WHI:    reg_rdata_out <= whi_q;
        OFS_MCTL:   reg_rdata_out <= mctl_q;
        OFS_RESULT: reg_rdata_out <= res_word;
        OFS_IE:     reg_rdata_out <= ie_q;
        OFS_IFG:    reg_rdata_out <= DATA_W'(flags_q);
        OFS_IV:     reg_rdata_out <= aic_vec_code(top); // [R6] [R12] [R13]
        default:    reg_rdata_out <= '0;
      endcase
    end
  end

  assign converter_power_on_out = ctl0_q.converter_power_on;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  ready_set_a: assert property (load |=> flags_q[FLG_READY]) // [R1]
    else $error("ready flag not set after result load");
  irq_gate_a: assert property (!global_irq_enable_in || pend == '0 |=> !irq_out) // [R2]
    else $error("interrupt raised without enable");
  ovf_set_a: assert property (load && unread_q && !rd_res |=> flags_q[FLG_OVF]) // [R3]
    else $error("overflow not flagged on unread result");
  tov_set_a: assert property (trig_req && busy && !auto_q |=> flags_q[FLG_TOV]) // [R4]
    else $error("time overflow not flagged");
  dma_gate_a: assert property (dma_trig_out |-> $past(load) && !$past(ie_q[FLG_READY])) // [R5]
    else $error("dma trigger without completed conversion or with ready enable");
  vec_top_a: assert property (rd_iv && pend[FLG_OVF] |=> reg_rdata_out == VEC_OVF) // [R12]
    else $error("overflow not reported as top vector");
  vec_mask_a: assert property (rd_iv && ie_q == '0 |=> reg_rdata_out == VEC_NONE) // [R7]
    else $error("disabled source affected vector");
  vec_ready_a: assert property (rd_iv && pend == (NUM_FLAGS'(1) << FLG_READY) |=> reg_rdata_out == VEC_READY) // [R13]
    else $error("ready source not coded lowest");
  iv_keep_ready_a: assert property (rd_iv && flags_q[FLG_READY] && !rd_res |=> flags_q[FLG_READY]) // [R8]
    else $error("vector read cleared ready flag");
  iv_write_a: assert property (reg_wr_in && reg_addr_in == OFS_IV && !load && !tov_evt |=> flags_q == '0) // [R10]
    else $error("vector write left flags set");
  res_read_a: assert property (rd_res && !load |=> !flags_q[FLG_READY]) // [R9]
    else $error("result read kept ready flag");
  irq_hold_a: assert property (global_irq_enable_in && pend != '0 |=> irq_out) // [R11]
    else $error("pending enabled source without interrupt");
  ctl0_read_a: assert property (reg_rd_in && reg_addr_in == OFS_CTL0 |=> reg_rdata_out[15:12] == 4'h0
    && !reg_rdata_out[CTL0_SC_BIT]) // [R16] [R18]
    else $error("reserved or start bit read back nonzero");
  lock_a: assert property (wr_ctl0 && locked |=> $stable(ctl0_q.sample_time_sel)) // [R17]
    else $error("sample time changed while enabled");
  window_low_a: assert property (load && res_in_word(conv_data_in) < wlo_q |=> flags_q[FLG_LOW]) // [R19]
    else $error("low window flag missing");
  auto_next_a: assert property (go_on && !abort |=> state_q == ST_SAMPLE) // [R15]
    else $error("automatic follow-on conversion missing");

  load_c: cover property (load ##1 dma_trig_out);
  vec_ovf_c: cover property (rd_iv && top[FLG_OVF]);
  auto_c: cover property (go_on ##[1:200] load);
  tov_c: cover property (tov_evt);

endmodule : aic_converter_ctl

// file: aic_core_model.sv
// aic_core_model: behavioural analog core answering each conversion start.
// assumes a one-cycle start pulse from the control block on the same clock.
module aic_core_model
  import aic_pkg::*;
#(
  parameter int DELAY = 3
)
(
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  input  wire logic             start_in,
  input  wire logic [RES_W-1:0] value_in,
  output logic                  done_out,
  output logic      [RES_W-1:0] data_out
);
  int cnt_q;
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cnt_q    <= 0;
      done_out <= 1'b0;
      data_out <= '0;
    end
    else
    begin
      done_out <= (cnt_q == 1);
      // scrambled outside done so a stale value never looks valid
      data_out <= (cnt_q == 1) ? value_in : ~data_out;
      if (start_in)
        cnt_q <= DELAY;
      else if (cnt_q != 0)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule : aic_core_model

// file: aic_converter_ctl_bench.sv
// aic_converter_ctl_bench: register table and conversion checks of aic_converter_ctl.
// assumes aic_core_model as analog core; converter tick held high, sample input driven by the bench.
module aic_converter_ctl_bench
  import aic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [DATA_W-1:0] e;} aic_row_s;
  logic              clk, rst, wr_en, rd_en, global_irq_enable, start, done, irq, dma, samp, sample_input_signal, pwr;
  logic [3:0]        chan;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [RES_W-1:0]  core_val, core_data;
  int                errors, tests_run, cycles, n0, n1;
  aic_row_s          rows [17] = '{
    '{0, OFS_CTL0, 16'h0, 16'h0}, '{0, OFS_CTL1, 16'h0, 16'h0}, '{0, OFS_CTL2, 16'h0, 16'h1000},
    '{0, OFS_WLO, 16'h0, 16'h0}, '{0, OFS_WHI, 16'h0, 16'hff03}, '{0, OFS_MCTL, 16'h0, 16'h0},
    '{0, OFS_RESULT, 16'h0, 16'h0}, '{0, OFS_IE, 16'h0, 16'h0}, '{0, OFS_IFG, 16'h0, 16'h0},
    '{0, OFS_IV, 16'h0, 16'h0}, '{1, 8'h20, 16'hffff, 16'h0}, '{1, OFS_CTL0, 16'hffec, 16'h0f80},
    '{1, OFS_CTL1, 16'hffff, 16'h0ffe}, '{1, OFS_CTL1, 16'h0, 16'h0}, '{1, OFS_WLO, 16'h0100, 16'h0100},
    '{1, OFS_WHI, 16'h0200, 16'h0200}, '{1, OFS_IE, 16'h003e, 16'h003e}};

  aic_converter_ctl aic_converter_ctl_i (
    .core_clk_in            (clk),
    .reset_in               (rst),
    .reg_addr_in            (addr),
    .reg_wdata_in           (wdata),
    .reg_wr_in              (wr_en),
    .reg_rd_in              (rd_en),
    .reg_rdata_out          (rdata),
    .global_irq_enable_in   (global_irq_enable),
    .converter_clock_in     (1'b1),
    .sample_input_signal_in (sample_input_signal),
    .conv_done_in           (done),
    .conv_data_in           (core_data),
    .irq_out                (irq),
    .dma_trig_out           (dma),
    .conv_start_out         (start),
    .sampling_out           (samp),
    .channel_out            (chan),
    .converter_power_on_out (pwr)
  );
  aic_core_model aic_core_model_i (
    .core_clk_in (clk),
    .reset_in    (rst),
    .start_in    (start),
    .value_in    (core_val),
    .done_out    (done),
    .data_out    (core_data)
  );

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp_v);
    tests_run++;
    if (seen !== exp_v)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp_v);
    end
  endtask : chk
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr_reg
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rc
  // enable dropped first so the sample-time field is taken
  task automatic conv(input logic [3:0] sht, input logic [RES_W-1:0] val, input logic twice, output int n);
    core_val <= val;
    wr_reg(OFS_CTL0, 16'h0010);
    wr_reg(OFS_CTL0, {4'h0, sht, 8'h13});
    if (twice)
      wr_reg(OFS_CTL0, {4'h0, sht, 8'h13});
    n = 0;
    for (int i = 0; i < 600 && dma !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
      n += int'(samp === 1'b1);
    end
    chk({15'h0, dma}, 16'h1);
    $display("conversion with sample code %h done", sht);
  endtask : conv
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      end_sim();
    end
  end

  initial
  begin
    rst      = 1'b1;
    {wr_en, rd_en, global_irq_enable} = 3'b001;
    addr     = '0;
    wdata    = '0;
    core_val = '0;
    sample_input_signal      = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr_reg(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    $display("register rows done");
    conv(4'h0, 10'h250, 1'b0, n0);
    rc(OFS_IFG, 16'h0009);
    chk({15'h0, irq}, 16'h1);
    rc(OFS_IV, VEC_HIGH);
    rc(OFS_IFG, 16'h0001);
    rc(OFS_IV, VEC_NONE);
    chk({15'h0, irq}, 16'h0);
    wr_reg(OFS_IE, 16'h003f);
    rc(OFS_IV, VEC_READY);
    rc(OFS_IFG, 16'h0001);
    wr_reg(OFS_IE, 16'h003e);
    rc(OFS_RESULT, 16'h0250);
    rc(OFS_IFG, 16'h0000);
    conv(4'h1, 10'h150, 1'b0, n1);
    chk(16'(n1 - n0), 16'h0004);
    conv(4'h0, 10'h050, 1'b0, n0);
    rc(OFS_IFG, 16'h0033);
    rc(OFS_IV, VEC_OVF);
    chk({15'h0, irq}, 16'h1);
    rc(OFS_IV, VEC_LOW);
    rc(OFS_IV, VEC_IN);
    wr_reg(OFS_IV, 16'h5a5a);
    rc(OFS_IFG, 16'h0000);
    rc(OFS_RESULT, 16'h0050);
    // second start lands while sampling is still running
    conv(4'h8, 10'h3ff, 1'b1, n1);
    rc(OFS_IFG, 16'h000d);
    chk({15'h0, irq}, 16'h1);
    @(posedge clk);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0);
    rc(OFS_IV, VEC_TOV);
    $display("interrupt scenarios done");
    // multi-sample sequence from channel 1: one edge, two results; a later edge is ignored
    wr_reg(OFS_CTL0, 16'h0010);
    wr_reg(OFS_MCTL, 16'h0001);
    wr_reg(OFS_CTL1, 16'h0002);
    wr_reg(OFS_CTL0, 16'h0092);
    core_val <= 10'h120;
    n0 = 0;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      sample_input_signal <= (i < 2) || (i == 8);
      #1;
      n0 += int'(dma === 1'b1);
    end
    chk(16'(n0), 16'h0002);
    rc(OFS_IFG, 16'h002b);
    chk({12'h0, chan}, 16'h0001);
    chk({15'h0, pwr}, 16'h1);
    $display("multi-sample sequence done");
    end_sim();
  end
endmodule : aic_converter_ctl_bench
